// File: include/acc_pkg.sv
/*
 * Shared constants for the converter core control block: register map,
 * field layouts, reset values, trigger codes and core timing.
 * Assumes a 32-bit APB master and word-aligned register accesses.
 */
package acc_pkg;
	// Sizes
	localparam int NUM_CORES  = 2;
	localparam int NUM_INPUTS = 21;
	localparam int NUM_TRIG   = 20;
	localparam int NUM_TREGS  = 10;
	localparam int NUM_EXT    = 32;

	// Register byte offsets
	localparam logic [11:0] OFS_CORE0   = 12'h000;
	localparam logic [11:0] OFS_CORE1   = 12'h004;
	localparam logic [11:0] OFS_ESTAT_L = 12'h008;
	localparam logic [11:0] OFS_ESTAT_H = 12'h00c;
	localparam logic [11:0] OFS_TRIG0   = 12'h010;
	localparam logic [11:0] OFS_SWTRIG  = 12'h038;

	// Core control field layout
	localparam int LEAD_LSB = 10;
	localparam int LEAD_MSB = 12;
	localparam int RES_LSB  = 8;
	localparam int RES_MSB  = 9;
	localparam int DIV_LSB  = 0;
	localparam int DIV_MSB  = 6;
	localparam logic [15:0] CORE_MASK  = 16'h1f7f;
	localparam logic [15:0] ESTATH_MASK = 16'h001f;
	localparam logic [15:0] TRIG_MASK  = 16'h1f1f;
	localparam int TRIG_HI_LSB = 8;
	localparam int TRIG_LO_LSB = 0;

	// Software trigger register bits
	localparam int SW_COMMON_BIT = 0;
	localparam int SW_LEVEL_BIT  = 1;

	// Reset values
	localparam logic [15:0] CORE_RST  = 16'h0000;
	localparam logic [4:0]  TRIG_RST  = 5'h00;

	// Trigger source codes
	localparam logic [4:0] TSRC_NONE   = 5'h00;
	localparam logic [4:0] TSRC_COMMON = 5'h01;
	localparam logic [4:0] TSRC_LEVEL  = 5'h02;
	localparam logic [4:0] TSRC_PIN    = 5'h1f;

	// Resolution codes and result widths
	localparam logic [1:0] RES_12 = 2'h3;
	localparam logic [1:0] RES_10 = 2'h2;
	localparam logic [1:0] RES_8  = 2'h1;
	localparam logic [1:0] RES_6  = 2'h0;
	localparam logic [4:0] BITS_12 = 5'h0c;
	localparam logic [4:0] BITS_10 = 5'h0a;
	localparam logic [4:0] BITS_8  = 5'h08;
	localparam logic [4:0] BITS_6  = 5'h06;

	// Core periods spent on sampling and transfer beyond the bit cycles
	localparam logic [4:0] CONV_OVERHEAD = 5'h02;
	// Divider codes at or below this give the minimum half period
	localparam logic [6:0] DIV_MIN = 7'h01;

	// Core sequencer states, Gray along idle -> convert
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_CONV = 2'b01
	} acc_state_t;
endpackage

// File: include/acc_core_if.sv
/*
 * Carrier between the control top and one dedicated core sequencer.
 * Assumes both ends share pclk.
 */
`timescale 1ns/1ns
interface acc_core_if;
	logic [2:0] lead;
	logic [1:0] res;
	logic [6:0] div;
	logic       start;
	logic       core_clk;
	logic       early;
	logic       ready;
	logic       busy;

	modport ctrl (output lead, output res, output div, output start,
		input core_clk, input early, input ready, input busy);
	modport core (input lead, input res, input div, input start,
		output core_clk, output early, output ready, output busy);
endinterface

// File: rtl/acc_core_seq.sv
/*
 * One dedicated core sequencer: core clock divider, conversion length
 * by resolution, early event ahead of data ready.
 * Assumes start is a same-clock pulse; starts while busy are ignored.
 */
`timescale 1ns/1ns
module acc_core_seq (
	// Clock and reset
	input  wire logic   pclk,
	input  wire logic   presetn,
	// Control side
	acc_core_if.core    cif
);
	import acc_pkg::*;

	logic [6:0]  half_q, half_d;
	logic        clk_q, clk_d;
	logic [4:0]  rem_q, rem_d;
	acc_state_t  st_q, st_d;
	logic        early_q, early_d;
	logic        ready_q, ready_d;
	logic [6:0]  half_len;
	logic        period_end;
	logic [4:0]  conv_len;

	// Codes 0 and 1 both give a two-period core clock
	assign half_len   = (cif.div <= DIV_MIN) ? DIV_MIN : cif.div; // RULE3
	assign period_end = (half_q == half_len - 7'h01) && clk_q;

	// Result width sets how many core periods a conversion takes
	always_comb begin
		case (cif.res) // RULE2
			RES_12:  conv_len = BITS_12 + CONV_OVERHEAD;
			RES_10:  conv_len = BITS_10 + CONV_OVERHEAD;
			RES_8:   conv_len = BITS_8 + CONV_OVERHEAD;
			default: conv_len = BITS_6 + CONV_OVERHEAD;
		endcase
	end

	// Divider, sequencer and event next values
	always_comb begin
		half_d  = half_q;
		clk_d   = clk_q;
		rem_d   = rem_q;
		st_d    = st_q;
		early_d = 1'b0;
		ready_d = 1'b0;
		// Core clock toggles every half_len source clocks
		if (half_q >= half_len - 7'h01) begin // RULE3
			half_d = 7'h00;
			clk_d  = ~clk_q;
		end else begin
			half_d = half_q + 7'h01;
		end
		case (st_q)
			ACC_IDLE: begin
				if (cif.start) begin
					rem_d = conv_len;
					st_d  = ACC_CONV;
				end
			end
			ACC_CONV: begin
				if (period_end) begin
					rem_d = rem_q - 5'h01;
					// Lead code n fires n+1 core periods before data ready
					if (rem_q - 5'h01 == {2'h0, cif.lead} + 5'h01)
						early_d = 1'b1; // RULE1
					if (rem_q == 5'h01) begin
						ready_d = 1'b1;
						st_d    = ACC_IDLE;
					end
				end
			end
			default: st_d = ACC_IDLE;
		endcase
	end

	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half_q  <= 7'h00;
			clk_q   <= 1'b0;
			rem_q   <= 5'h00;
			st_q    <= ACC_IDLE;
			early_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			half_q  <= half_d;
			clk_q   <= clk_d;
			rem_q   <= rem_d;
			st_q    <= st_d;
			early_q <= early_d;
			ready_q <= ready_d;
		end
	end

	assign cif.core_clk = clk_q;
	assign cif.early    = early_q;
	assign cif.ready    = ready_q;
	assign cif.busy     = (st_q == ACC_CONV);
endmodule // acc_core_seq

// File: rtl/acc_top.sv
/*
 * Converter core control: per-core clock, resolution and early event
 * lead, early event flags per input, trigger source selection for inputs 0 to 19,
 * all behind an APB slave with one wait state.
 * Assumes ext_trig and ext_early come from other clock domains and are
 * synchronised here; buf_rd comes from logic on pclk.
 */
// Overview of operation
// RULE1 - Each core raises its early event a chosen 1 to 8 core periods before data ready.
// RULE2 - A 2-bit field picks 12, 10, 8 or 6-bit results per core.
// RULE3 - A core period is twice the divider code in source clocks, codes 0 and 1 giving two.
// RULE4 - Software keeps lead codes 100 to 111 away from 6-bit resolution.
// RULE5 - Software keeps lead codes 110 and 111 away from 8-bit resolution.
// RULE6 - Twenty-one early flags, split over a low and a high status register, record events.
// RULE7 - Reading an input's result buffer clears that input's early flag.
// RULE8 - Each trigger register holds two 5-bit selections, odd input high and even low.
// RULE9 - Trigger code 0 is none, 1 common software, 2 level software, 31 the pin input.
// RULE10 - Unimplemented bits of these registers read as zero.
`timescale 1ns/1ns
module acc_top (
	// Clock and reset
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	// APB slave
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [11:0]                     paddr,
	input  wire logic [31:0]                     pwdata,
	output logic      [31:0]                     prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// Trigger and early event sources
	input  wire logic [acc_pkg::NUM_EXT-1:0]     ext_trig,
	input  wire logic [acc_pkg::NUM_INPUTS-1:0]  ext_early,
	input  wire logic [acc_pkg::NUM_INPUTS-1:0]  buf_rd,
	// Converter side
	output logic [acc_pkg::NUM_TRIG-1:0]         trig_req,
	output logic [acc_pkg::NUM_CORES-1:0]        core_clk,
	output logic [acc_pkg::NUM_CORES-1:0]        core_early,
	output logic [acc_pkg::NUM_CORES-1:0]        core_ready,
	output logic [acc_pkg::NUM_CORES-1:0]        core_busy
);
	import acc_pkg::*;

	logic [15:0]            ctrl_q [NUM_CORES];
	logic [15:0]            ctrl_d [NUM_CORES];
	logic [4:0]             tsel_q [NUM_TRIG];
	logic [4:0]             tsel_d [NUM_TRIG];
	logic [NUM_INPUTS-1:0]  flag_q, flag_d;
	logic                   level_q, level_d;
	logic                   common_q, common_d;
	logic [31:0]            prdata_q, prdata_d;
	logic                   pready_q, pready_d;
	logic                   perr_q, perr_d;
	logic [NUM_EXT-1:0]     xt_s1_q, xt_s2_q, xt_s3_q;
	logic [NUM_INPUTS-1:0]  xe_s1_q, xe_s2_q, xe_s3_q;
	logic [NUM_TRIG-1:0]    treq_q, treq_d;
	logic [NUM_CORES-1:0]   cclk_q, cearly_q, cready_q, cbusy_q;
	logic [NUM_EXT-1:0]     xt_evt;
	logic [NUM_INPUTS-1:0]  early_set;
	logic                   acc_cyc;
	logic                   addr_hit;
	logic                   wr_en;
	logic                   rd_en;

	acc_core_if cif [NUM_CORES] ();

	// Trigger register index of an address, or NUM_TREGS when outside
	function automatic logic [3:0] trig_idx(input logic [11:0] a);
		logic [11:0] rel;
		rel = a - OFS_TRIG0;
		if (a >= OFS_TRIG0 && rel[11:2] < 10'(NUM_TREGS) && rel[1:0] == 2'h0)
			trig_idx = rel[5:2];
		else
			trig_idx = 4'(NUM_TREGS);
	endfunction

	// Does the selected source fire this cycle
	function automatic logic trig_hit(input logic [4:0] code, input logic [NUM_EXT-1:0] evt,
		input logic com, input logic lvl);
		if (code == TSRC_NONE)
			trig_hit = 1'b0; // RULE9
		else if (code == TSRC_COMMON)
			trig_hit = com; // RULE9
		else if (code == TSRC_LEVEL)
			trig_hit = lvl; // RULE9
		else
			trig_hit = evt[code]; // RULE9
	endfunction

	// Access phase is answered one cycle after it opens
	assign acc_cyc  = psel && penable && !pready_q;
	assign addr_hit = paddr == OFS_CORE0 || paddr == OFS_CORE1 || paddr == OFS_ESTAT_L ||
		paddr == OFS_ESTAT_H || paddr == OFS_SWTRIG || trig_idx(paddr) != 4'(NUM_TREGS);
	// Writes land on the edge where the master sees pready, never earlier
	assign wr_en    = psel && penable && pready_q && pwrite && !perr_q;
	assign rd_en    = acc_cyc && !pwrite && addr_hit;

	// Rising edges of synchronised pins; third stage only delays stage two
	assign xt_evt = xt_s2_q & ~xt_s3_q;

	// Early events: dedicated cores own inputs 0 and 1, pins the rest
	always_comb begin
		early_set = xe_s2_q & ~xe_s3_q;
		for (int c = 0; c < NUM_CORES; c++)
			early_set[c] = cearly_q[c];
	end

	// Dedicated core sequencers
	generate
		for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
			assign cif[c].lead  = ctrl_q[c][LEAD_MSB:LEAD_LSB];
			assign cif[c].res   = ctrl_q[c][RES_MSB:RES_LSB];
			assign cif[c].div   = ctrl_q[c][DIV_MSB:DIV_LSB];
			assign cif[c].start = treq_q[c];
			acc_core_seq u_seq (
				.pclk    (pclk),
				.presetn (presetn),
				.cif     (cif[c])
			);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cclk_q[c]   <= 1'b0;
					cearly_q[c] <= 1'b0;
					cready_q[c] <= 1'b0;
					cbusy_q[c]  <= 1'b0;
				end else begin
					cclk_q[c]   <= cif[c].core_clk;
					cearly_q[c] <= cif[c].early;
					cready_q[c] <= cif[c].ready;
					cbusy_q[c]  <= cif[c].busy;
				end
			end
		end
	endgenerate

	// Register file next values and APB answer
	always_comb begin
		logic [3:0] ti;
		ti       = trig_idx(paddr);
		ctrl_d   = ctrl_q;
		tsel_d   = tsel_q;
		level_d  = level_q;
		common_d = 1'b0;
		flag_d   = flag_q;
		prdata_d = prdata_q;
		pready_d = acc_cyc;
		// Unmapped places answer with an error and are never written
		perr_d   = acc_cyc && !addr_hit;
		// Writes, masked so unimplemented bits stay zero
		if (wr_en) begin
			if (paddr == OFS_CORE0)
				ctrl_d[0] = pwdata[15:0] & CORE_MASK; // RULE10
			else if (paddr == OFS_CORE1)
				ctrl_d[1] = pwdata[15:0] & CORE_MASK; // RULE10
			else if (paddr == OFS_ESTAT_L)
				flag_d[15:0] = pwdata[15:0];
			else if (paddr == OFS_ESTAT_H)
				flag_d[20:16] = pwdata[4:0];
			else if (paddr == OFS_SWTRIG) begin
				common_d = pwdata[SW_COMMON_BIT];
				level_d  = pwdata[SW_LEVEL_BIT];
			end else begin
				tsel_d[2*ti]   = pwdata[TRIG_LO_LSB +: 5]; // RULE8
				tsel_d[2*ti+1] = pwdata[TRIG_HI_LSB +: 5]; // RULE8
			end
		end
		// Result buffer reads clear flags
		flag_d = flag_d & ~buf_rd; // RULE7
		// A new event wins over a clear in the same cycle
		flag_d = flag_d | early_set; // RULE6
		// Reads
		if (rd_en) begin
			if (paddr == OFS_CORE0)
				prdata_d = {16'h0000, ctrl_q[0]};
			else if (paddr == OFS_CORE1)
				prdata_d = {16'h0000, ctrl_q[1]};
			else if (paddr == OFS_ESTAT_L)
				prdata_d = {16'h0000, flag_q[15:0]}; // RULE6
			else if (paddr == OFS_ESTAT_H)
				prdata_d = {16'h0000, {11'h000, flag_q[20:16]} & ESTATH_MASK}; // RULE10
			else if (paddr == OFS_SWTRIG)
				prdata_d = {30'h00000000, level_q, 1'b0};
			else
				prdata_d = {19'h00000, tsel_q[2*ti+1], 3'h0, tsel_q[2*ti]}; // RULE10
		end else if (acc_cyc) begin
			prdata_d = 32'h00000000;
		end
		// Trigger requests per input
		for (int i = 0; i < NUM_TRIG; i++)
			treq_d[i] = trig_hit(tsel_q[i], xt_evt, common_q, level_q); // RULE9
	end

	// Registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NUM_CORES; c++)
				ctrl_q[c] <= CORE_RST;
			for (int i = 0; i < NUM_TRIG; i++)
				tsel_q[i] <= TRIG_RST;
			flag_q   <= '0;
			level_q  <= 1'b0;
			common_q <= 1'b0;
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			perr_q   <= 1'b0;
			treq_q   <= '0;
			xt_s1_q  <= '0;
			xt_s2_q  <= '0;
			xt_s3_q  <= '0;
			xe_s1_q  <= '0;
			xe_s2_q  <= '0;
			xe_s3_q  <= '0;
		end else begin
			ctrl_q   <= ctrl_d;
			tsel_q   <= tsel_d;
			flag_q   <= flag_d;
			level_q  <= level_d;
			common_q <= common_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			perr_q   <= perr_d;
			treq_q   <= treq_d;
			xt_s1_q  <= ext_trig;
			xt_s2_q  <= xt_s1_q;
			xt_s3_q  <= xt_s2_q;
			xe_s1_q  <= ext_early;
			xe_s2_q  <= xe_s1_q;
			xe_s3_q  <= xe_s2_q;
		end
	end

	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = perr_q;
	assign trig_req   = treq_q;
	assign core_clk   = cclk_q;
	assign core_early = cearly_q;
	assign core_ready = cready_q;
	assign core_busy  = cbusy_q;
endmodule // acc_top

// File: tb/acc_checker.sv
/* Port-level assertions for the converter core control top.
   Assumes one clock domain and an APB master that holds its request. */
`timescale 1ns/1ns
module acc_checker
	import acc_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Converter side
	input wire logic [1:0]  core_clk,
	input wire logic [1:0]  core_early,
	input wire logic [1:0]  core_ready,
	input wire logic [1:0]  core_busy
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Cycles core 0 clock stood still; a stalled divider makes it grow
	logic       clk0_q, clk0_d;
	logic [7:0] hold_q, hold_d;
	always_comb begin
		clk0_d = core_clk[0];
		hold_d = (core_clk[0] != clk0_q) ? 8'h00 : hold_q + 8'h01;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk0_q <= 1'h0;
			hold_q <= 8'h00;
		end else begin
			clk0_q <= clk0_d;
			hold_q <= hold_d;
		end
	end

	// Setup phase, then exactly one wait state
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		!pready ##1 pready;
	endsequence
	property p_wait;
		s_setup |=> s_answer;
	endproperty
	a_wait: assert property (p_wait)
		else $error("apb answer not after one wait state");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("pready held past one cycle");
	property p_err;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_err: assert property (p_err)
		else $error("error response malformed");
	property p_wr_zero;
		pready && pwrite |-> prdata == 32'h0;
	endproperty
	a_wr_zero: assert property (p_wr_zero)
		else $error("read data driven on a write");
	property p_core_rsv;
		pready && !pwrite && paddr < OFS_ESTAT_L |-> (prdata & ~{16'h0, CORE_MASK}) == 32'h0;
	endproperty
	a_core_rsv: assert property (p_core_rsv)
		else $error("core control unused bits not zero");
	property p_stat_rsv;
		pready && !pwrite && paddr == OFS_ESTAT_H |-> prdata[31:5] == 27'h0;
	endproperty
	a_stat_rsv: assert property (p_stat_rsv)
		else $error("high flag register unused bits not zero");
	property p_trig_rsv;
		pready && !pwrite && paddr >= OFS_TRIG0 && paddr < OFS_SWTRIG
			|-> (prdata & ~{16'h0, TRIG_MASK}) == 32'h0;
	endproperty
	a_trig_rsv: assert property (p_trig_rsv)
		else $error("trigger select unused bits not zero");
	property p_early;
		core_early[0] |-> core_busy[0] && !core_ready[0] ##1 !core_ready[0];
	endproperty
	a_early: assert property (p_early)
		else $error("early event not ahead of data ready");
	property p_div;
		hold_q <= 8'h80;
	endproperty
	a_div: assert property (p_div)
		else $error("core clock half period too long");
endmodule // acc_checker

bind acc_top acc_checker u_chk (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.core_clk(core_clk),
	.core_early(core_early),
	.core_ready(core_ready),
	.core_busy(core_busy)
);

// File: tb/acc_src_model.sv
/* Model of trigger pins, early event lines and result buffer reads.
   Assumes its tasks are called right after a rising pclk edge. */
`timescale 1ns/1ns
module acc_src_model (
	// Clock
	input  wire logic   pclk,
	// Lines into the block
	output logic [31:0] ext_trig,
	output logic [20:0] ext_early,
	output logic [20:0] buf_rd
);
	// Idle lines rest low
	initial begin
		ext_trig = 32'h0;
		ext_early = 21'h0;
		buf_rd = 21'h0;
	end
	// Pin edge held four cycles so the two-stage sync cannot miss it
	task automatic pin_edge();
		ext_trig[31] <= 1'h1;
		repeat (4) @(posedge pclk);
		ext_trig[31] <= 1'h0;
	endtask
	task automatic early_edge(input int i);
		ext_early[i] <= 1'h1;
		repeat (4) @(posedge pclk);
		ext_early[i] <= 1'h0;
	endtask
	// A result buffer read is one pclk pulse
	task automatic buf_read(input int i);
		buf_rd[i] <= 1'h1;
		@(posedge pclk);
		buf_rd[i] <= 1'h0;
	endtask
endmodule // acc_src_model

// File: tb/acc_top_bench.sv
/* Self-checking bench for the converter core control top.
   Assumes the source model drives trigger pins, early lines and reads. */
`timescale 1ns/1ns
module acc_top_bench;
	import acc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic [31:0] ext_trig;
	logic [20:0] ext_early, buf_rd;
	logic [19:0] trig_req;
	logic [1:0]  core_clk, core_early, core_ready, core_busy, rs;
	logic [2:0]  ld;
	logic [6:0]  dv;
	logic [4:0]  codes [4] = '{TSRC_NONE, TSRC_COMMON, TSRC_LEVEL, TSRC_PIN};
	int          err_total = 0, check_count = 0, cyc = 0, bcnt = 0;
	int          te = 0, tr = 0, tcnt = 0, t0;

	acc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_trig(ext_trig),
		.ext_early(ext_early), .buf_rd(buf_rd), .trig_req(trig_req),
		.core_clk(core_clk), .core_early(core_early), .core_ready(core_ready),
		.core_busy(core_busy));
	acc_src_model src (.pclk(pclk), .ext_trig(ext_trig), .ext_early(ext_early),
		.buf_rd(buf_rd));

	initial pclk = 1'h0;
	always #25 pclk = ~pclk;

	// Event times and counts; pre-edge values are read, so no race
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (core_busy[0] === 1'h1)
			bcnt <= bcnt + 1;
		if (core_early[0] === 1'h1)
			te <= cyc;
		if (core_ready[0] === 1'h1)
			tr <= cyc;
		if (trig_req[1] === 1'h1)
			tcnt <= tcnt + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready is seen; a hang fails the check
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		chk({31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	function automatic logic [15:0] msk(input int a);
		if (a < int'(OFS_ESTAT_L))
			return CORE_MASK;
		if (a == int'(OFS_ESTAT_L))
			return 16'hffff;
		if (a == int'(OFS_ESTAT_H))
			return ESTATH_MASK;
		return TRIG_MASK;
	endfunction
	task automatic half(output int n);
		logic c;
		c = core_clk[0];
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (core_clk[0] === c && n < 300);
	endtask
	// Core 0 run: clock period, early lead, length and flag
	task automatic conv();
		int n, p, b, b0, r0;
		p = (dv > 7'h01) ? 2 * int'(dv) : 2;
		b = 2 * int'(rs) + 6;
		apb(1'h1, OFS_CORE0, {16'h0, 3'h0, ld, rs, 1'h0, dv});
		apb(1'h1, OFS_ESTAT_L, 32'h0);
		half(n);
		half(n);
		chk(32'(n), 32'(p / 2));
		b0 = bcnt;
		r0 = tr;
		apb(1'h1, OFS_SWTRIG, 32'h1);
		n = 0;
		while (tr == r0 && n < 8000) begin
			@(posedge pclk);
			n++;
		end
		repeat (3) @(posedge pclk);
		chk(32'(tr - te), 32'((int'(ld) + 1) * p));
		n = bcnt - b0;
		chk(32'(n >= (b + 1) * p && n <= (b + 2) * p + 1), 32'h1);
		apb(1'h0, OFS_ESTAT_L, 32'h0);
		chk(rd, 32'h1);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog well above the expected run length
	initial begin
		repeat (60000) @(posedge pclk);
		err_total++;
		end_sim();
	end

	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		void'($urandom(32'h486b1252));
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		// Reset values, then an unmapped place
		for (int a = 0; a <= 'h38; a += 4) begin
			apb(1'h0, 12'(a), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'h1, 12'h040, 32'hffffffff);
		chk({31'h0, er}, 32'h1);
		// Random write and read back through the field masks
		for (int i = 0; i < 14; i++) begin
			v = $urandom();
			// Core control keeps 12-bit results so any lead code is legal
			if (i < 2)
				v[9:8] = RES_12;
			apb(1'h1, 12'(4 * i), v);
			apb(1'h0, 12'(4 * i), 32'h0);
			chk(rd, {16'h0, v[15:0] & msk(4 * i)});
			apb(1'h1, 12'(4 * i), 32'h0);
		end
		// Flags: buffer reads clear, early events set
		apb(1'h1, OFS_ESTAT_L, 32'hffff);
		src.buf_read(3);
		apb(1'h0, OFS_ESTAT_L, 32'h0);
		chk(rd, 32'hfff7);
		apb(1'h1, OFS_ESTAT_H, 32'h1f);
		src.buf_read(20);
		apb(1'h0, OFS_ESTAT_H, 32'h0);
		chk(rd, 32'h0f);
		apb(1'h1, OFS_ESTAT_L, 32'h0);
		src.early_edge(5);
		repeat (6) @(posedge pclk);
		apb(1'h0, OFS_ESTAT_L, 32'h0);
		chk(rd, 32'h20);
		// Each of the four named trigger source codes on input 1; level counts while it is set
		for (int k = 0; k < 4; k++) begin
			apb(1'h1, OFS_TRIG0, {19'h0, codes[k], 8'h00});
			t0 = tcnt;
			if (k == 3)
				src.pin_edge();
			else
				apb(1'h1, OFS_SWTRIG, (k == 2) ? 32'h2 : 32'h1);
			repeat (12) @(posedge pclk);
			if (k == 2)
				apb(1'h1, OFS_SWTRIG, 32'h0);
			repeat (8) @(posedge pclk);
			chk(32'((k == 2) ? (tcnt - t0 > 8) : (tcnt - t0 == k % 2)), 32'h1);
		end
		// Conversions: all leads at 12 bits, then each resolution
		apb(1'h1, OFS_TRIG0, {27'h0, TSRC_COMMON});
		for (int i = 0; i < 12; i++) begin
			rs = (i < 8) ? RES_12 : 2'(i - 8);
			ld = (i < 8) ? 3'(i) : 3'($urandom_range((rs == RES_6) ? 3 : (rs == RES_8) ? 5 : 7));
			dv = (i == 0) ? 7'h00 : (i == 1) ? 7'h01 : (i == 2) ? 7'h7f : 7'($urandom_range(6, 2));
			conv();
		end
		end_sim();
	end
endmodule // acc_top_bench
